// ### src/ssf_pkg.sv
// Constants, register map and types of the serial status flag block.
// Assumes a 50 MHz bus clock and software access over APB.
`default_nettype none

package ssf_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCK_HALF_NS   = 80;
  localparam int SCK_HALF_CYC  =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_LOAD_MAX_CYC = 2;
  localparam int SPI_DATA_W        = 8;

  // Register byte offsets
  localparam logic [7:0] CTRL1_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] DATA_OFS     = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

  // Control one fields
  localparam int CTRL_EN_BIT     = 6;
  localparam int CTRL_TIE_BIT    = 5;
  localparam int CTRL_MASTER_SELECT_BIT   = 4;
  localparam int CTRL_SELECT_OUTPUT_ENABLE_BIT   = 1;
  localparam int CTRL_MODE_FAULT_ENABLE_BIT = 0;

  // Status fields
  localparam int ST_RFF_BIT  = 7;
  localparam int ST_OVR_BIT  = 6;
  localparam int ST_TEF_BIT  = 5;
  localparam int ST_MODE_FAULT_FLAG_BIT = 4;

  // Interrupt status and mask fields
  localparam int IRQ_W        = 4;
  localparam int IRQ_RFF_BIT  = 0;
  localparam int IRQ_TEF_BIT  = 1;
  localparam int IRQ_MODE_FAULT_FLAG_BIT = 2;
  localparam int IRQ_OVR_BIT  = 3;

  // Values after reset
  localparam logic [7:0]       CTRL1_RST = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RST  = 4'h0;
  localparam logic [7:0]       DATA_RST  = 8'h00;

  typedef enum logic [1:0] {
    SSF_IDLE  = 2'b00,
    SSF_LEAD  = 2'b01,
    SSF_TRAIL = 2'b10
  } ssf_shift_state_t;

  function automatic logic ssf_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    return addr == ofs;
  endfunction : ssf_hit

endpackage : ssf_pkg

`default_nettype wire

// ### src/ssf_shifter.sv
// Eight-bit serial shifter, clock phase 0, most significant bit first.
// Assumes sck_in, ser_in and ss_n_in are already synchronised.
`default_nettype none

module ssf_shifter
  import ssf_pkg::*;
#(
  parameter int DATA_W   = SPI_DATA_W,
  parameter int HALF_CYC = SCK_HALF_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              master,
  input  wire logic              load,
  input  wire logic [DATA_W-1:0] load_data,
  input  wire logic              sck_in,
  input  wire logic              ser_in,
  input  wire logic              ss_n_in,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rx_data,
  output logic                   sck_out,
  output logic                   ser_out
);

  localparam int DW = $clog2(HALF_CYC + 1);
  localparam int BW = $clog2(DATA_W);

  ssf_shift_state_t  state;
  ssf_shift_state_t  next_state;
  logic [DATA_W-1:0] shreg;
  logic [DATA_W-1:0] next_shreg;
  logic [DATA_W-1:0] next_rx_data;
  logic [BW-1:0]     bit_cnt;
  logic [BW-1:0]     next_bit_cnt;
  logic [DW-1:0]     div_cnt;
  logic [DW-1:0]     next_div_cnt;
  logic              pending;
  logic              next_pending;
  logic              sck_prev;
  logic              in_bit;
  logic              next_in_bit;
  logic              next_sck_out;
  logic              next_ser_out;
  logic              next_done;
  logic              tick;
  logic              rise;
  logic              fall;
  logic              advance;

  assign busy = (state != SSF_IDLE) | pending;

  always_comb begin
    rise         = sck_in & ~sck_prev;
    fall         = ~sck_in & sck_prev;
    tick         = (div_cnt == DW'(HALF_CYC - 1));
    advance      = master ? tick : ((state == SSF_TRAIL) ? fall : rise);
    next_state   = state;
    next_shreg   = shreg;
    next_rx_data = rx_data;
    next_bit_cnt = bit_cnt;
    next_pending = pending;
    next_in_bit  = in_bit;
    next_sck_out = sck_out;
    next_ser_out = ser_out;
    next_done    = 1'b0;
    next_div_cnt = (state == SSF_IDLE || tick) ? '0 : div_cnt + 1'b1;
    case (state)
      SSF_IDLE: begin
        if (load) begin
          next_shreg   = load_data;
          next_ser_out = load_data[DATA_W-1];
          next_bit_cnt = '0;
          // Slave waits with the byte parked until the partner clocks
          next_pending = ~master;
          if (master) begin
            next_state = SSF_LEAD;
          end
        end else if (~master && ~ss_n_in && rise) begin
          next_in_bit  = ser_in;
          next_pending = 1'b0;
          next_state   = SSF_TRAIL;
        end
      end
      SSF_LEAD: begin
        if (advance) begin
          next_in_bit  = ser_in;
          next_sck_out = master;
          next_state   = SSF_TRAIL;
        end
      end
      SSF_TRAIL: begin
        if (advance) begin
          next_sck_out = 1'b0;
          next_shreg   = {shreg[DATA_W-2:0], in_bit};
          if (bit_cnt == BW'(DATA_W - 1)) begin
            next_done    = 1'b1;
            next_rx_data = {shreg[DATA_W-2:0], in_bit};
            next_state   = SSF_IDLE;
          end else begin
            next_bit_cnt = bit_cnt + 1'b1;
            next_ser_out = shreg[DATA_W-2];
            next_state   = SSF_LEAD;
          end
        end
      end
      default: begin
        next_state = SSF_IDLE;
      end
    endcase
    // Select released mid byte: slave drops the partial byte
    if (~master && ss_n_in && state != SSF_IDLE) begin
      next_state   = SSF_IDLE;
      next_bit_cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= SSF_IDLE;
      shreg    <= '0;
      rx_data  <= '0;
      bit_cnt  <= '0;
      div_cnt  <= '0;
      pending  <= 1'b0;
      sck_prev <= 1'b0;
      in_bit   <= 1'b0;
      sck_out  <= 1'b0;
      ser_out  <= 1'b0;
      done     <= 1'b0;
    end else if (ce) begin
      state    <= next_state;
      shreg    <= next_shreg;
      rx_data  <= next_rx_data;
      bit_cnt  <= next_bit_cnt;
      div_cnt  <= next_div_cnt;
      pending  <= next_pending;
      sck_prev <= sck_in;
      in_bit   <= next_in_bit;
      sck_out  <= next_sck_out;
      ser_out  <= next_ser_out;
      done     <= next_done;
    end
  end

endmodule : ssf_shifter

`default_nettype wire

// ### src/ssf_spi_status.sv
// Serial interface status flags, one-deep transmit queue, mode fault.
// Assumes an APB master on REF_CLK; link pins are asynchronous.
//
// Behaviour
// - Transfer completion sets receive-full, status bit 7
// - Receive-full clears after status read with it set, then data read
// - Transmit-empty, status bit 5, is 1 while transmit buffer has room
// - Transmit-empty clears after status read with it set, then data write
// - Data write without prior armed status read is ignored
// - Interrupt while transmit-empty and its enable are both set
// - Buffer to shifter move sets transmit-empty
// - Idle interface passes written byte on; flag back within two cycles
// - Shifter completion pulls a waiting byte and sets transmit-empty
// - Empty buffer at completion: flag stays set, nothing moves
// - Master with select input low sets mode-fault, status bit 4
// - Mode fault only with master, fault enable on, select output off
// - Mode-fault clears after status read with it set, then ctrl write
// - In master mode a queued byte starts a transfer
// - Transfer ending before receive read flags overrun, drops new byte
`default_nettype none

module ssf_spi_status
  import ssf_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE,
  input  wire logic        MOSI_I,
  output logic             MOSI_O,
  output logic             MOSI_OE,
  input  wire logic        MISO_I,
  output logic             MISO_O,
  output logic             MISO_OE,
  input  wire logic        SS_N_I,
  output logic             SS_N_O,
  output logic             SS_N_OE
);

  logic [3:0]       sync1;
  logic [3:0]       sync2;
  logic             sck_s;
  logic             mosi_s;
  logic             miso_s;
  logic             ss_n_s;
  logic [7:0]       ctrl;
  logic [7:0]       next_ctrl;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] irq_evt;
  logic [7:0]       tx_buf;
  logic [7:0]       next_tx_buf;
  logic [7:0]       rx_buf;
  logic [7:0]       next_rx_buf;
  logic [7:0]       status;
  logic             tx_full;
  logic             next_tx_full;
  logic             receive_full_flag;
  logic             next_rff;
  logic             transmit_empty_flag;
  logic             next_tef;
  logic             mode_fault_flag;
  logic             next_mode_fault_flag;
  logic             overrun;
  logic             next_ovr;
  logic             rff_arm;
  logic             next_rff_arm;
  logic             tef_arm;
  logic             next_tef_arm;
  logic             mode_fault_flag_arm;
  logic             next_mode_fault_flag_arm;
  logic [31:0]      next_prdata;
  logic             next_pready;
  logic             next_pslverr;
  logic             next_irq;
  logic             next_sck_oe;
  logic             next_miso_oe;
  logic             next_ss_oe;
  logic             next_ss_n;
  logic             acc;
  logic             mapped;
  logic             wr_ctrl;
  logic             wr_data;
  logic             wr_irq;
  logic             wr_mask;
  logic             rd_status;
  logic             rd_data;
  logic             load_shift;
  logic             fault_cond;
  logic             rff_clear;
  logic             shift_busy;
  logic             shift_done;
  logic [7:0]       shift_rx;
  logic             ser_out;

  logic enable;
  logic master_select;
  logic transmit_empty_irq_enable;
  logic select_output_enable;
  logic mode_fault_enable;

  assign enable                    = ctrl[CTRL_EN_BIT];
  assign master_select             = ctrl[CTRL_MASTER_SELECT_BIT];
  assign transmit_empty_irq_enable = ctrl[CTRL_TIE_BIT];
  assign select_output_enable      = ctrl[CTRL_SELECT_OUTPUT_ENABLE_BIT];
  assign mode_fault_enable         = ctrl[CTRL_MODE_FAULT_ENABLE_BIT];
  assign {sck_s, mosi_s, miso_s, ss_n_s} = sync2;
  assign status = {receive_full_flag, overrun, transmit_empty_flag,
                   mode_fault_flag, 4'h0};
  assign MOSI_O  = ser_out;
  assign MISO_O  = ser_out;
  assign MOSI_OE = SCK_OE;

  // Pin synchronisers: the first stage feeds only the second
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1 <= 4'h7;
      sync2 <= 4'h7;
    end else if (CE) begin
      sync1 <= {SCK_I, MOSI_I, MISO_I, SS_N_I};
      sync2 <= sync1;
    end
  end

  // APB: one wait state so read data comes from a flop
  always_comb begin
    acc          = PSEL & PENABLE;
    mapped       = ssf_hit(PADDR, CTRL1_OFS) | ssf_hit(PADDR, STATUS_OFS) |
                   ssf_hit(PADDR, DATA_OFS) | ssf_hit(PADDR, IRQ_STAT_OFS) |
                   ssf_hit(PADDR, IRQ_MASK_OFS);
    next_pready  = acc & ~PREADY;
    next_pslverr = acc & ~PREADY & ~mapped;
    next_prdata  = PRDATA;
    if (acc && !PREADY && !PWRITE) begin
      next_prdata = 32'h0000_0000;
      case (1'b1)
        ssf_hit(PADDR, CTRL1_OFS):    next_prdata[7:0] = ctrl;
        ssf_hit(PADDR, STATUS_OFS):   next_prdata[7:0] = status;
        ssf_hit(PADDR, DATA_OFS):     next_prdata[7:0] = rx_buf;
        ssf_hit(PADDR, IRQ_STAT_OFS): next_prdata[IRQ_W-1:0] = irq_stat;
        ssf_hit(PADDR, IRQ_MASK_OFS): next_prdata[IRQ_W-1:0] = irq_mask;
        default:                      next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  // Flags, queue and interrupt state
  always_comb begin
    wr_ctrl   = acc & PREADY & PWRITE & ssf_hit(PADDR, CTRL1_OFS);
    wr_data   = acc & PREADY & PWRITE & ssf_hit(PADDR, DATA_OFS);
    wr_irq    = acc & PREADY & PWRITE & ssf_hit(PADDR, IRQ_STAT_OFS);
    wr_mask   = acc & PREADY & PWRITE & ssf_hit(PADDR, IRQ_MASK_OFS);
    rd_status = acc & PREADY & ~PWRITE & ssf_hit(PADDR, STATUS_OFS);
    rd_data   = acc & PREADY & ~PWRITE & ssf_hit(PADDR, DATA_OFS);
    load_shift = tx_full & ~shift_busy & enable;
    fault_cond = enable & master_select & mode_fault_enable &
                 ~select_output_enable & ~ss_n_s;
    rff_clear  = rd_data & rff_arm;
    next_ctrl     = wr_ctrl ? PWDATA[7:0] : ctrl;
    next_irq_mask = wr_mask ? PWDATA[IRQ_W-1:0] : irq_mask;
    next_tx_buf   = tx_buf;
    next_tx_full  = tx_full;
    next_tef      = transmit_empty_flag;
    next_rx_buf   = rx_buf;
    next_rff      = receive_full_flag;
    next_ovr      = overrun;
    next_mode_fault_flag     = mode_fault_flag;
    irq_evt       = '0;
    // Arming follows the status value that software actually saw
    next_rff_arm  = rff_arm;
    next_tef_arm  = tef_arm;
    next_mode_fault_flag_arm = mode_fault_flag_arm;
    if (rd_status) begin
      next_rff_arm  = PRDATA[ST_RFF_BIT];
      next_tef_arm  = PRDATA[ST_TEF_BIT];
      next_mode_fault_flag_arm = PRDATA[ST_MODE_FAULT_FLAG_BIT];
    end
    if (rd_data) begin
      next_rff_arm = 1'b0;
    end
    if (wr_ctrl) begin
      next_mode_fault_flag_arm = 1'b0;
    end
    if (rff_clear) begin
      next_rff = 1'b0;
      next_ovr = 1'b0;
    end
    if (load_shift) begin
      next_tx_full = 1'b0;
      next_tef     = 1'b1;
      irq_evt[IRQ_TEF_BIT] = 1'b1;
    end
    if (wr_data) begin
      next_tef_arm = 1'b0;
      if (tef_arm) begin
        next_tx_buf  = PWDATA[7:0];
        next_tx_full = 1'b1;
        next_tef     = 1'b0;
      end
    end
    // Completion with a full receive buffer not cleared in the same cycle keeps the old byte
    if (shift_done) begin
      if (receive_full_flag && !rff_clear) begin
        next_ovr = 1'b1;
        irq_evt[IRQ_OVR_BIT] = 1'b1;
      end else begin
        next_rx_buf = shift_rx;
        next_rff    = 1'b1;
        irq_evt[IRQ_RFF_BIT] = 1'b1;
      end
    end
    if (wr_ctrl && mode_fault_flag_arm) begin
      next_mode_fault_flag = 1'b0;
    end
    if (fault_cond) begin
      next_mode_fault_flag = 1'b1;
      irq_evt[IRQ_MODE_FAULT_FLAG_BIT] = ~mode_fault_flag;
    end
    next_irq_stat = (irq_stat & ~(wr_irq ? PWDATA[IRQ_W-1:0] : '0)) |
                    irq_evt;
    next_irq = (|(irq_stat & irq_mask)) |
               (transmit_empty_flag & transmit_empty_irq_enable);
    next_sck_oe  = enable & master_select;
    next_miso_oe = enable & ~master_select & ~ss_n_s;
    next_ss_oe   = enable & master_select & select_output_enable;
    next_ss_n    = ~shift_busy;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl                <= CTRL1_RST;
      irq_mask            <= MASK_RST;
      irq_stat            <= '0;
      tx_buf              <= DATA_RST;
      tx_full             <= 1'b0;
      transmit_empty_flag <= 1'b1;
      rx_buf              <= DATA_RST;
      receive_full_flag   <= 1'b0;
      overrun             <= 1'b0;
      mode_fault_flag     <= 1'b0;
      rff_arm             <= 1'b0;
      tef_arm             <= 1'b0;
      mode_fault_flag_arm            <= 1'b0;
      IRQ                 <= 1'b0;
      SCK_OE              <= 1'b0;
      MISO_OE             <= 1'b0;
      SS_N_OE             <= 1'b0;
      SS_N_O              <= 1'b1;
    end else if (CE) begin
      ctrl                <= next_ctrl;
      irq_mask            <= next_irq_mask;
      irq_stat            <= next_irq_stat;
      tx_buf              <= next_tx_buf;
      tx_full             <= next_tx_full;
      transmit_empty_flag <= next_tef;
      rx_buf              <= next_rx_buf;
      receive_full_flag   <= next_rff;
      overrun             <= next_ovr;
      mode_fault_flag     <= next_mode_fault_flag;
      rff_arm             <= next_rff_arm;
      tef_arm             <= next_tef_arm;
      mode_fault_flag_arm            <= next_mode_fault_flag_arm;
      IRQ                 <= next_irq;
      SCK_OE              <= next_sck_oe;
      MISO_OE             <= next_miso_oe;
      SS_N_OE             <= next_ss_oe;
      SS_N_O              <= next_ss_n;
    end
  end

  ssf_shifter #(
    .DATA_W   (SPI_DATA_W),
    .HALF_CYC (SCK_HALF_CYC)
  ) u_shifter (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .ce        (CE),
    .master    (master_select),
    .load      (load_shift),
    .load_data (tx_buf),
    .sck_in    (sck_s),
    .ser_in    (master_select ? miso_s : mosi_s),
    .ss_n_in   (ss_n_s),
    .busy      (shift_busy),
    .done      (shift_done),
    .rx_data   (shift_rx),
    .sck_out   (SCK_O),
    .ser_out   (ser_out)
  );

  // Flag is back on the move edge that follows the write
  localparam int LOAD_LAST = IDLE_LOAD_MAX_CYC - 1;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  rff_set_a: assert property (
    CE && shift_done && !receive_full_flag |=> receive_full_flag
  ) else $error("receive-full not set on completion");

  rff_clear_a: assert property (
    CE && rff_clear && !shift_done |=> !receive_full_flag
  ) else $error("receive-full not cleared by read sequence");

  early_write_a: assert property (
    CE && wr_data && !tef_arm && !tx_full |=> !tx_full
  ) else $error("unarmed data write was queued");

  idle_pass_a: assert property (
    (CE && wr_data && tef_arm && !shift_busy && enable) ##1 CE
      |-> ##[0:LOAD_LAST] transmit_empty_flag
  ) else $error("transmit-empty not back within two cycles");

  tef_irq_a: assert property (
    CE && transmit_empty_flag && transmit_empty_irq_enable |=> IRQ
  ) else $error("transmit-empty interrupt missing");

  empty_done_a: assert property (
    CE && shift_done && !tx_full && transmit_empty_flag && !wr_data
      |=> transmit_empty_flag && !tx_full
  ) else $error("transmit-empty dropped with empty buffer");

  mode_fault_flag_gate_a: assert property (
    $rose(mode_fault_flag) |-> $past(master_select) &&
      $past(mode_fault_enable) && !$past(select_output_enable) &&
      !$past(ss_n_s)
  ) else $error("mode fault set outside master fault mode");

  overrun_keep_a: assert property (
    CE && shift_done && receive_full_flag && !rff_clear
      |=> overrun && $stable(rx_buf)
  ) else $error("overrun not flagged or byte overwritten");

endmodule : ssf_spi_status

`default_nettype wire

// ### testbench/ssf_partner.sv
// Far-side model: a mode 0 slave, most significant bit first.
// Assumes the block is master and drives clock, data and select.
`default_nettype none

module ssf_partner (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte,
  output int              n_rx
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] sh;
  logic [7:0] rx_sh;
  int         bits;

  initial begin
    miso    = 1'b0;
    rx_byte = 8'h00;
    rx_sh   = 8'h00;
    n_rx    = 0;
    bits    = 0;
  end

  // Released line shows the inverse, so a stale bit can never pass
  always @(posedge ss_n) miso = ~miso;

  always @(negedge ss_n) begin
    sh   = tx_byte;
    bits = 0;
    miso = sh[7];
  end

  always @(posedge sck) if (!ss_n) begin
    rx_sh = {rx_sh[6:0], mosi};
    bits++;
    if (bits == 8) begin
      rx_byte = rx_sh;
      n_rx++;
      bits = 0;
    end
  end

  // Next byte is loaded on the closing edge of a finished one
  always @(negedge sck) if (!ss_n) begin
    if (bits == 0) sh = tx_byte;
    else sh = sh << 1;
    miso = sh[7];
  end
endmodule : ssf_partner

`default_nettype wire

// ### testbench/tb_spi_status_flags.sv
// Self-checking bench of the serial status flag block over APB.
// Assumes ssf_partner as far side; the block runs as master, and as slave in half of the mode-fault loop.
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
  end end

module tb_spi_status_flags;
  import ssf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, rst_n, psel, penable, pwrite, ss_ext, ce;
  logic [7:0]  paddr, tx_byte, rx_byte, a, b, pa, pb;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, sck_o, mosi_o, miso_o, ss_n_o;
  logic        sck_oe, mosi_oe, miso_oe, ss_n_oe, p_miso;
  wire logic   ss_wire, miso_wire;
  logic [32:0] e, m;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  int          n_rx, num_errors, n_tests;

  assign ss_wire   = ss_n_oe ? ss_n_o : ss_ext;
  assign miso_wire = miso_oe ? miso_o : p_miso;

  ssf_spi_status DUT (
    .REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
    .SCK_I(1'b0), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(1'b0),
    .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_wire),
    .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_N_I(ss_wire),
    .SS_N_O(ss_n_o), .SS_N_OE(ss_n_oe));

  ssf_partner u_partner (
    .sck(sck_o), .mosi(mosi_o), .ss_n(ss_wire), .tx_byte(tx_byte),
    .miso(p_miso), .rx_byte(rx_byte), .n_rx(n_rx));

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  // Answer checker: oldest note against each completed transfer
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK("apb answer", e & m, {pslverr, prdata} & m)
    end
  end

  task automatic give_verdict();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic hang();
    num_errors++;
    give_verdict();
  endtask : hang

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, input logic [32:0] ex,
                     input logic [32:0] mk);
    int k;
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang();
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 33'h0_0000_0000, 33'h1_0000_0000);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] ex,
                    input logic [31:0] mk);
    apb(1'b0, ad, 32'h0000_0000, {1'b0, ex}, {1'b1, mk});
  endtask : rd

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (n_rx < n && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    if (n_rx < n) hang();
  endtask : wait_rx

  initial begin
    logic [2:0] f;
    ref_clk = 1'b0;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    ss_ext  = 1'b1;
    ce      = 1'b1;
    tx_byte = 8'h00;
    num_errors = 0;
    n_tests    = 0;
    void'($urandom(71));
    {a, b, pa, pb} = $urandom();
    // Distinct partner bytes, so an overwritten receive byte shows
    pb = ~pa;
    cyc(6);
    rst_n <= 1'b1;
    rd(CTRL1_OFS, {24'h00_0000, CTRL1_RST}, 32'hFFFF_FFFF);
    rd(IRQ_MASK_OFS, {28'h000_0000, MASK_RST}, 32'hFFFF_FFFF);
    rd(IRQ_STAT_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b0, 8'h14, 32'h0000_0000, 33'h1_0000_0000, 33'h1_0000_0000);
    apb(1'b1, 8'h14, 32'h0000_00FF, 33'h1_0000_0000, 33'h1_0000_0000);
    wr(CTRL1_OFS, 32'h0000_0053);
    wr(DATA_OFS, {24'h00_0000, b});
    cyc(10);
    `CHK("bytes sent", 0, n_rx)
    `CHK("select", 1'b1, ss_wire)
    `CHK("clock drive", 1'b1, sck_oe)
    `CHK("mosi drive", 1'b1, mosi_oe)
    rd(STATUS_OFS, 32'h0000_0020, 32'hFFFF_FFFF);
    tx_byte <= pa;
    wr(DATA_OFS, {24'h00_0000, a});
    rd(STATUS_OFS, 32'h0000_0020, 32'hFFFF_FFFF);
    tx_byte <= pb;
    wr(DATA_OFS, {24'h00_0000, b});
    rd(STATUS_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    // Clock enable low must hold the byte in flight
    ce <= 1'b0;
    cyc(100);
    `CHK("frozen bytes", 0, n_rx)
    ce <= 1'b1;
    wait_rx(1);
    `CHK("first byte", a, rx_byte)
    wait_rx(2);
    `CHK("second byte", b, rx_byte)
    cyc(80);
    `CHK("bytes sent", 2, n_rx)
    `CHK("select", 1'b1, ss_wire)
    rd(STATUS_OFS, 32'h0000_00E0, 32'hFFFF_FFFF);
    rd(DATA_OFS, {24'h00_0000, pa}, 32'hFFFF_FFFF);
    rd(STATUS_OFS, 32'h0000_0020, 32'hFFFF_FFFF);
    wr(STATUS_OFS, 32'h0000_00FF);
    rd(STATUS_OFS, 32'h0000_0020, 32'hFFFF_FFFF);
    rd(IRQ_STAT_OFS, 32'h0000_000B, 32'hFFFF_FFFF);
    wr(CTRL1_OFS, 32'h0000_0073);
    cyc(2);
    `CHK("irq", 1'b1, irq)
    wr(CTRL1_OFS, 32'h0000_0053);
    cyc(2);
    `CHK("irq", 1'b0, irq)
    wr(IRQ_MASK_OFS, 32'h0000_0001);
    cyc(2);
    `CHK("irq", 1'b1, irq)
    wr(IRQ_STAT_OFS, 32'h0000_000F);
    cyc(2);
    `CHK("irq", 1'b0, irq)
    rd(IRQ_STAT_OFS, 32'h0000_0000, 32'h0000_0001);
    // Index 6 is master, fault enable on, select output off
    for (int i = 0; i < 8; i++) begin
      f = i[2:0];
      wr(CTRL1_OFS, {24'h00_0000, 3'b010, f[2], 2'b00, f[0], f[1]});
      ss_ext <= 1'b0;
      cyc(6);
      rd(STATUS_OFS, {27'h000_0000, f == 3'b110, 4'h0}, 32'h0000_0010);
      `CHK("clock drive", f[2], sck_oe)
      `CHK("miso drive", ~f[2], miso_oe)
      ss_ext <= 1'b1;
    end
    give_verdict();
  end
endmodule : tb_spi_status_flags

`default_nettype wire
